// ---- mds_supervisor.sv ----
// Motor drive supervisor: gates, protection, timers, scan sequencer, APB registers.
// Overview of operation
// - Run indicator lit while motor runs.
// - Fault indicator lit while error latched.
// - Position indicator lit when positioning completed.
// - Toggle switch is the start/stop command.
// - Switch low runs; software may command instead.
// - Fault clear switch returns to normal.
// - Complementary gates with dead time, polarities fixed.
// - Quadrature phase order steps count up/down.
// - Overcurrent falling edge floats all gates.
// - Short circuit also floats all gates.
// - Interval tick every 500 microseconds.
// - Free-running timer for speed measurement.
// - Hardware-triggered single scan of four channels.
// - Both phase currents sampled at once.
// - Hall edges raise events.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "mds_cfg.svh"
module mds_supervisor #(
  parameter int TICK_CYC = `MDS_TICK_US * `MDS_CLK_MHZ,
  parameter int DEAD_CYC = (`MDS_DEAD_NS * `MDS_CLK_MHZ + 999) / 1000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_toggle_switch,
  input wire logic fault_clear_switch,
  input wire logic overcurrent_stop_n,
  input wire logic short_detect,
  input wire logic quad_in_a,
  input wire logic quad_in_b,
  input wire logic hall_u_event,
  input wire logic hall_v_event,
  input wire logic hall_w_event,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [1:0] adc_chan,
  output logic sample_hold,
  output logic gate_u_high,
  output logic gate_v_high,
  output logic gate_w_high,
  output logic gate_u_low,
  output logic gate_v_low,
  output logic gate_w_low,
  output logic gate_oe,
  output logic run_indicator,
  output logic fault_indicator,
  output logic position_done_indicator,
  output logic irq
);
  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  // Bit order: 0 run switch, 1 clear switch, 2 overcurrent_n, 3 short, 4..6 hall, 7 done.
  logic [7:0] pin_s1_q; // First stage, read only by the second stage.
  logic [7:0] pin_q; // Synchronised pins.
  logic [7:0] pin_prev_q; // Previous synchronised value, for edges.
  logic [11:0] data_s1_q; // First stage of converter data.
  logic [11:0] data_q; // Converter data, stable by the time done rises.

  // Pins are plain registers here, so no next-value logic is needed.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= `MDS_PIN_RST;
      pin_q <= `MDS_PIN_RST;
      pin_prev_q <= `MDS_PIN_RST;
      data_s1_q <= 12'h000;
      data_q <= 12'h000;
    end else begin
      pin_s1_q <= {adc_done, hall_w_event, hall_v_event, hall_u_event, short_detect,
                   overcurrent_stop_n, fault_clear_switch, run_toggle_switch};
      pin_q <= pin_s1_q;
      pin_prev_q <= pin_q;
      data_s1_q <= adc_data;
      data_q <= data_s1_q;
    end
  end

  logic oc_fall; // Overcurrent pin fell.
  logic clr_rise; // Fault clear switch pressed.
  logic [2:0] hall_edge; // Either edge on a hall input.
  logic done_rise; // Converter finished a channel.
  assign oc_fall = pin_prev_q[2] & ~pin_q[2];
  assign clr_rise = pin_q[1] & ~pin_prev_q[1];
  assign hall_edge = pin_q[6:4] ^ pin_prev_q[6:4];
  assign done_rise = pin_q[7] & ~pin_prev_q[7];

  // ****************************************************************
  // Register file over APB.
  // ****************************************************************
  logic [2:0] ctrl_q, ctrl_d; // Source select, software run, position done.
  logic [15:0] period_q, period_d; // Half carrier period in cycles.
  logic [15:0] duty_q [3], duty_d [3]; // Per-phase compare values.
  logic [`MDS_IRQ_W-1:0] ien_q, ien_d; // Interrupt enables.
  logic [`MDS_IRQ_W-1:0] ist_q, ist_d; // Sticky interrupt status.
  logic [`MDS_IRQ_W-1:0] ev; // Events of this cycle.
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic [31:0] free_q; // Free-running timer.
  logic [15:0] enc_cnt, enc_cap;
  mds_pkg::mds_sample_t res_q [4];
  logic running_q, fault_q;
  logic wr_en; // Write lands at the edge where pready is sampled high.
  logic hit; // Address decodes to a register.

  assign wr_en = psel & penable & rdy_q & pwrite;

  // Decode, write effects and read mux; a read has no side effect.
  always_comb begin
    ctrl_d = ctrl_q;
    period_d = period_q;
    duty_d = duty_q;
    ien_d = ien_q;
    hit = 1'b1;
    rd_d = 32'h0000_0000;
    unique case (paddr)
      `MDS_OFF_CTRL: rd_d = {29'h0, ctrl_q};
      `MDS_OFF_STATUS: rd_d = {27'h0, pin_q[6:4], fault_q, running_q};
      `MDS_OFF_PERIOD: rd_d = {16'h0, period_q};
      `MDS_OFF_DUTY_U: rd_d = {16'h0, duty_q[0]};
      `MDS_OFF_DUTY_V: rd_d = {16'h0, duty_q[1]};
      `MDS_OFF_DUTY_W: rd_d = {16'h0, duty_q[2]};
      `MDS_OFF_ENC_CNT: rd_d = {16'h0, enc_cnt};
      `MDS_OFF_ENC_CAP: rd_d = {16'h0, enc_cap};
      `MDS_OFF_FREE_TMR: rd_d = free_q;
      `MDS_OFF_ADC_IU: rd_d = {20'h0, res_q[0]};
      `MDS_OFF_ADC_IW: rd_d = {20'h0, res_q[1]};
      `MDS_OFF_ADC_VDC: rd_d = {20'h0, res_q[2]};
      `MDS_OFF_ADC_CMD: rd_d = {20'h0, res_q[3]};
      `MDS_OFF_IRQ_STAT: rd_d = {26'h0, ist_q};
      `MDS_OFF_IRQ_CLR: rd_d = 32'h0000_0000;
      `MDS_OFF_IRQ_EN: rd_d = {26'h0, ien_q};
      default: hit = 1'b0;
    endcase
    if (wr_en) begin
      unique case (paddr)
        `MDS_OFF_CTRL: ctrl_d = pwdata[2:0];
        `MDS_OFF_PERIOD: period_d = pwdata[15:0];
        `MDS_OFF_DUTY_U: duty_d[0] = pwdata[15:0];
        `MDS_OFF_DUTY_V: duty_d[1] = pwdata[15:0];
        `MDS_OFF_DUTY_W: duty_d[2] = pwdata[15:0];
        `MDS_OFF_IRQ_EN: ien_d = pwdata[`MDS_IRQ_W-1:0];
        default: ien_d = ien_q;
      endcase
    end
    // Set wins over a clear written in the same cycle, so no event is lost.
    ist_d = ist_q & ~((wr_en && paddr == `MDS_OFF_IRQ_CLR) ? pwdata[`MDS_IRQ_W-1:0] :
                      {`MDS_IRQ_W{1'b0}});
    ist_d = ist_d | ev;
    // Answer one cycle into the access phase; an unmapped address errors.
    rdy_d = psel & penable & ~rdy_q;
    err_d = rdy_d & ~hit;
  end

  // Register the bus group.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 3'h0;
      period_q <= `MDS_PERIOD_RST;
      duty_q <= '{16'h0000, 16'h0000, 16'h0000};
      ien_q <= {`MDS_IRQ_W{1'b0}};
      ist_q <= {`MDS_IRQ_W{1'b0}};
      rd_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      period_q <= period_d;
      duty_q <= duty_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      rd_q <= rdy_d ? rd_d : rd_q;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // ****************************************************************
  // Run, fault and indicator state.
  // ****************************************************************
  logic run_req, fault_cause, fault_d, running_d;
  logic tick_q, tick_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;

  // Software source replaces the switch only when selected.
  assign run_req = ctrl_q[`MDS_CTRL_SRC] ? ctrl_q[`MDS_CTRL_RUN] : ~pin_q[0];
  assign fault_cause = ~pin_q[2] | pin_q[3];

  // A clear only takes while the cause is gone; a new fault edge still wins.
  always_comb begin
    fault_d = fault_q;
    if (clr_rise && !fault_cause) begin
      fault_d = 1'b0;
    end
    if (oc_fall || pin_q[3]) begin
      fault_d = 1'b1;
    end
    running_d = run_req & ~fault_d;
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h1;
    if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
      tick_cnt_d = 32'h0;
      tick_d = 1'b1;
    end
    ev = {`MDS_IRQ_W{1'b0}};
    ev[`MDS_IRQ_TICK] = tick_q;
    ev[`MDS_IRQ_HALL +: 3] = hall_edge;
    ev[`MDS_IRQ_FAULT] = fault_d & ~fault_q;
    ev[`MDS_IRQ_ADC] = scan_end;
  end

  // Register run and fault state, timers and the visible indicators.
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_q <= 1'b0;
      running_q <= 1'b0;
      tick_q <= 1'b0;
      tick_cnt_q <= 32'h0;
      free_q <= 32'h0;
      run_indicator <= 1'b0;
      fault_indicator <= 1'b0;
      position_done_indicator <= 1'b0;
      irq <= 1'b0;
    end else begin
      fault_q <= fault_d;
      running_q <= running_d;
      tick_q <= tick_d;
      tick_cnt_q <= tick_cnt_d;
      free_q <= free_q + 32'h1;
      run_indicator <= running_q;
      fault_indicator <= fault_q;
      position_done_indicator <= ctrl_q[`MDS_CTRL_POS];
      irq <= |(ist_q & ien_q);
    end
  end

  // ****************************************************************
  // Carrier and dead-time gate generation.
  // ****************************************************************
  logic [15:0] car_q, car_d;
  logic up_q, up_d;
  logic peak; // Carrier top, the scan trigger.
  logic [2:0] hi_d, lo_d, hi_q, lo_q;
  logic oe_q;

  assign peak = up_q && car_q >= period_q;

  // Triangle carrier counting up to the period and back down.
  always_comb begin
    car_d = up_q ? car_q + 16'h1 : car_q - 16'h1;
    up_d = up_q;
    if (peak) begin
      up_d = 1'b0;
      car_d = car_q - 16'h1;
    end else if (!up_q && car_q == 16'h0) begin
      up_d = 1'b1;
      car_d = 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      car_q <= 16'h0;
      up_q <= 1'b1;
    end else begin
      car_q <= car_d;
      up_q <= up_d;
    end
  end

  // Each phase holds both sides off while the wanted state differs from the applied one.
  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic ph_q, ph_d, want;
    logic [15:0] dt_q, dt_d;
    assign want = duty_q[p] > car_q;
    always_comb begin
      ph_d = ph_q;
      dt_d = 16'h0;
      if (want != ph_q) begin
        dt_d = dt_q + 16'h1;
        if (dt_q == 16'(DEAD_CYC - 1)) begin
          ph_d = want;
          dt_d = 16'h0;
        end
      end
      hi_d[p] = running_q && want == ph_q && ph_q;
      lo_d[p] = running_q && want == ph_q && !ph_q;
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        ph_q <= 1'b0;
        dt_q <= 16'h0;
      end else begin
        ph_q <= ph_d;
        dt_q <= dt_d;
      end
    end
  end

  // Upper gates active low, lower gates active high; a fault floats all.
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_q <= 3'h7;
      lo_q <= 3'h0;
      oe_q <= 1'b0;
    end else begin
      hi_q <= ~hi_d;
      lo_q <= lo_d;
      oe_q <= ~fault_q;
    end
  end
  assign gate_u_high = hi_q[0];
  assign gate_v_high = hi_q[1];
  assign gate_w_high = hi_q[2];
  assign gate_u_low = lo_q[0];
  assign gate_v_low = lo_q[1];
  assign gate_w_low = lo_q[2];
  assign gate_oe = oe_q;

  // ****************************************************************
  // Encoder counter and converter scan.
  // ****************************************************************
  mds_enc_if enc_if ();
  assign enc_if.capture = tick_q;
  assign enc_cnt = enc_if.count;
  assign enc_cap = enc_if.cap;
  mds_quad_counter u_enc (
    .clk(clk),
    .rst(rst),
    .quad_in_a(quad_in_a),
    .quad_in_b(quad_in_b),
    .enc(enc_if.enc)
  );

  mds_pkg::mds_adc_state_t st_q, st_d;
  logic [1:0] ch_q, ch_d;
  logic sh_d, start_d, scan_end;
  mds_pkg::mds_sample_t res_d [4];

  // A carrier peak holds both currents together, then converts channels in turn.
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    sh_d = 1'b0;
    start_d = 1'b0;
    res_d = res_q;
    scan_end = 1'b0;
    unique case (st_q)
      mds_pkg::MDS_ADC_IDLE: begin
        if (peak) begin
          st_d = mds_pkg::MDS_ADC_HOLD;
          sh_d = 1'b1;
        end
      end
      mds_pkg::MDS_ADC_HOLD: begin
        st_d = mds_pkg::MDS_ADC_CONV;
        ch_d = 2'h0;
      end
      mds_pkg::MDS_ADC_CONV: begin
        start_d = 1'b1;
        st_d = mds_pkg::MDS_ADC_WAIT;
      end
      mds_pkg::MDS_ADC_WAIT: begin
        if (done_rise) begin
          res_d[ch_q] = data_q;
          ch_d = ch_q + 2'h1;
          st_d = mds_pkg::MDS_ADC_CONV;
          if (ch_q == 2'(`MDS_ADC_NCH - 1)) begin
            st_d = mds_pkg::MDS_ADC_IDLE;
            scan_end = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= mds_pkg::MDS_ADC_IDLE;
      ch_q <= 2'h0;
      res_q <= '{12'h000, 12'h000, 12'h000, 12'h000};
      sample_hold <= 1'b0;
      adc_start <= 1'b0;
      adc_chan <= 2'h0;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      res_q <= res_d;
      sample_hold <= sh_d;
      adc_start <= start_d;
      adc_chan <= ch_d;
    end
  end

  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  sequence s_oc_edge;
    oc_fall;
  endsequence
  sequence s_float;
    ##2 !gate_oe;
  endsequence
  chk_run_led_on: assert property (@(posedge clk) disable iff (rst)
    $rose(running_q) |=> run_indicator)
    else $error("run indicator did not follow running");
  chk_fault_led_on: assert property (@(posedge clk) disable iff (rst)
    fault_q |=> fault_indicator)
    else $error("fault indicator dark while fault latched");
  chk_pos_led_off: assert property (@(posedge clk) disable iff (rst)
    !ctrl_q[`MDS_CTRL_POS] |=> !position_done_indicator)
    else $error("position indicator lit without completion");
  chk_switch_start: assert property (@(posedge clk) disable iff (rst)
    (!ctrl_q[`MDS_CTRL_SRC] && !pin_q[0] && !fault_d) |=> running_q)
    else $error("switch low did not start the motor");
  chk_oc_float: assert property (@(posedge clk) disable iff (rst)
    s_oc_edge |-> s_float)
    else $error("gates not floated after overcurrent edge");
  chk_short_float: assert property (@(posedge clk) disable iff (rst)
    pin_q[3] |-> ##2 !gate_oe)
    else $error("gates not floated on short circuit");
  chk_fault_hold: assert property (@(posedge clk) disable iff (rst)
    (fault_q && !clr_rise) |=> fault_q)
    else $error("fault left without a clear press");
  chk_clear_recover: assert property (@(posedge clk) disable iff (rst)
    (fault_q && clr_rise && !fault_cause && !oc_fall) |=> !fault_q)
    else $error("clear press did not leave the fault state");
  chk_dead_gap: assert property (@(posedge clk) disable iff (rst)
    $fell(gate_u_low) |-> gate_u_high [*8])
    else $error("upper gate turned on inside the dead time");
  chk_tick_gap: assert property (@(posedge clk) disable iff (rst)
    tick_q |=> !tick_q [*8])
    else $error("interval tick repeated too soon");
  chk_scan_hold: assert property (@(posedge clk) disable iff (rst)
    (st_q == mds_pkg::MDS_ADC_IDLE && peak) |=> sample_hold ##2 adc_start && adc_chan == 2'h0)
    else $error("scan did not hold then start channel zero");
  chk_hall_event: assert property (@(posedge clk) disable iff (rst)
    hall_edge[0] |=> ist_q[`MDS_IRQ_HALL])
    else $error("hall edge did not set its status bit");
endmodule : mds_supervisor

// ---- mds_cfg.svh ----
// Offsets, field positions, reset values and timing figures of the motor drive supervisor.
`ifndef MDS_CFG_SVH
`define MDS_CFG_SVH
// ****************************************************************
// Register byte offsets on the APB slave.
// ****************************************************************
`define MDS_OFF_CTRL 8'h00
`define MDS_OFF_STATUS 8'h04
`define MDS_OFF_PERIOD 8'h08
`define MDS_OFF_DUTY_U 8'h0c
`define MDS_OFF_DUTY_V 8'h10
`define MDS_OFF_DUTY_W 8'h14
`define MDS_OFF_ENC_CNT 8'h18
`define MDS_OFF_ENC_CAP 8'h1c
`define MDS_OFF_FREE_TMR 8'h20
`define MDS_OFF_ADC_IU 8'h24
`define MDS_OFF_ADC_IW 8'h28
`define MDS_OFF_ADC_VDC 8'h2c
`define MDS_OFF_ADC_CMD 8'h30
`define MDS_OFF_IRQ_STAT 8'h34
`define MDS_OFF_IRQ_CLR 8'h38
`define MDS_OFF_IRQ_EN 8'h3c
// ****************************************************************
// Field positions.
// ****************************************************************
`define MDS_CTRL_SRC 0
`define MDS_CTRL_RUN 1
`define MDS_CTRL_POS 2
`define MDS_ST_RUN 0
`define MDS_ST_FAULT 1
`define MDS_ST_HALL 2
`define MDS_IRQ_TICK 0
`define MDS_IRQ_HALL 1
`define MDS_IRQ_FAULT 4
`define MDS_IRQ_ADC 5
`define MDS_IRQ_W 6
// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define MDS_PERIOD_RST 16'h09c4
`define MDS_CLK_MHZ 100
`define MDS_DEAD_NS 2000
`define MDS_TICK_US 500
`define MDS_ADC_NCH 4
// Idle levels of the synchronised pins: run switch released, overcurrent pin high.
`define MDS_PIN_RST 8'h05
`endif

// ---- mds_pkg.sv ----
// Types shared by the motor drive supervisor modules.
package mds_pkg;
  // ****************************************************************
  // Converter scan sequencer states and sample type.
  // ****************************************************************
  typedef enum logic [1:0] {MDS_ADC_IDLE, MDS_ADC_HOLD, MDS_ADC_CONV, MDS_ADC_WAIT} mds_adc_state_t;
  typedef logic [11:0] mds_sample_t;
endpackage : mds_pkg

// ---- mds_enc_if.sv ----
// Interface between the supervisor top and its quadrature counter.
`timescale 1ns/1ps
interface mds_enc_if;
  logic capture; // One-cycle request to latch the count.
  logic [15:0] count; // Live position count.
  logic [15:0] cap; // Latched position count.
  modport top (output capture, input count, input cap);
  modport enc (input capture, output count, output cap);
endinterface : mds_enc_if

// ---- mds_quad_counter.sv ----
// Quadrature encoder position counter with capture register.
`timescale 1ns/1ps
module mds_quad_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic quad_in_a,
  input wire logic quad_in_b,
  mds_enc_if.enc enc
);
  // ****************************************************************
  // Pin synchronisers and count state.
  // ****************************************************************
  logic [1:0] s1_q; // First stage, read only by the second stage.
  logic [1:0] s2_q; // Synchronised A and B.
  logic [1:0] prev_q; // A and B one cycle earlier.
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cap_q, cap_d;

  // Four-edge decode: a move forward when the new A equals the old B.
  always_comb begin
    cnt_d = cnt_q;
    cap_d = enc.capture ? cnt_q : cap_q;
    if ((s2_q ^ prev_q) == 2'h1 || (s2_q ^ prev_q) == 2'h2) begin
      if (s2_q[0] ^ prev_q[1]) begin
        cnt_d = cnt_q - 16'h0001;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // Registers only; a double step (both pins changed) is dropped as noise.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      prev_q <= 2'h0;
      cnt_q <= 16'h0000;
      cap_q <= 16'h0000;
    end else begin
      s1_q <= {quad_in_b, quad_in_a};
      s2_q <= s1_q;
      prev_q <= s2_q;
      cnt_q <= cnt_d;
      cap_q <= cap_d;
    end
  end

  assign enc.count = cnt_q;
  assign enc.cap = cap_q;

  // The count holds while both synchronised pins are still.
  chk_count_still: assert property (@(posedge clk) disable iff (rst)
    (s2_q == prev_q) |=> (cnt_q == $past(cnt_q)))
    else $error("encoder count moved without an input edge");
endmodule : mds_quad_counter

// ---- mds_adc_model.sv ----
// Converter model that answers the supervisor's scan requests.
`timescale 1ns/1ps
module mds_adc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_start,
  input wire logic [1:0] adc_chan,
  output logic adc_done,
  output logic [11:0] adc_data
);
  // ****************************************************************
  // Conversion timing.
  // ****************************************************************
  logic [4:0] age_q; // Cycles since the last start; all ones means idle.
  // Data settle before done rises and stay until done has fallen.
  // Afterwards the data turn over, so a late read cannot pass by luck.
  always @(posedge clk) begin
    if (rst) begin
      age_q <= 5'h1f;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end else begin
      if (adc_start) begin
        age_q <= 5'h00;
        adc_data <= 12'h5a0 | {10'h000, adc_chan};
      end else if (age_q != 5'h1f) begin
        age_q <= age_q + 5'h01;
      end
      adc_done <= (age_q >= 5'h04) && (age_q < 5'h0c);
      if (age_q == 5'h10) adc_data <= ~adc_data;
    end
  end
endmodule : mds_adc_model

// ---- tb.sv ----
// Self-checking bench of the motor drive supervisor.
`timescale 1ns/1ps
`include "mds_cfg.svh"
module tb;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, adc_done, adc_start, sample_hold, irq, gate_oe;
  logic [11:0] adc_data;
  logic [1:0] adc_chan;
  logic run_toggle_switch = 1'b1, fault_clear_switch = 1'b0, overcurrent_stop_n = 1'b1;
  logic short_detect = 1'b0, quad_in_a = 1'b0, quad_in_b = 1'b0;
  logic hall_u_event = 1'b0, hall_v_event = 1'b0, hall_w_event = 1'b0;
  logic gate_u_high, gate_v_high, gate_w_high, gate_u_low, gate_v_low, gate_w_low;
  logic run_indicator, fault_indicator, position_done_indicator;
  int bad_count = 0, checks_done = 0, cyc = 0;
  // Short tick and dead time keep the run brief.
  mds_supervisor #(.TICK_CYC(50), .DEAD_CYC(10)) u_dut (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_toggle_switch,
    .fault_clear_switch, .overcurrent_stop_n, .short_detect, .quad_in_a, .quad_in_b,
    .hall_u_event, .hall_v_event, .hall_w_event, .adc_done, .adc_data, .adc_start,
    .adc_chan, .sample_hold, .gate_u_high, .gate_v_high, .gate_w_high, .gate_u_low,
    .gate_v_low, .gate_w_low, .gate_oe, .run_indicator, .fault_indicator,
    .position_done_indicator, .irq);
  mds_adc_model u_adc (.clk, .rst, .adc_start, .adc_chan, .adc_done, .adc_data);
  always #5 clk = ~clk;
  // A hang is cut short well beyond the expected length of the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic press();
    fault_clear_switch <= 1'b1;
    wt(6);
    fault_clear_switch <= 1'b0;
    wt(6);
  endtask : press
  task automatic step(input logic [1:0] ab);
    quad_in_a <= ab[1];
    quad_in_b <= ab[0];
    wt(6);
  endtask : step
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset_and_run();
    chk("gates idle", {gate_u_high, gate_v_high, gate_w_high, gate_u_low, gate_v_low,
      gate_w_low}, 6'h38);
    chk("indicators", {run_indicator, fault_indicator, position_done_indicator}, 3'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", er, 1'b1);
    run_toggle_switch <= 1'b0;
    wt(12);
    chk("run on", run_indicator, 1'b1);
    run_toggle_switch <= 1'b1;
    wt(12);
    chk("run off", run_indicator, 1'b0);
    apb(1'b1, `MDS_OFF_CTRL, 32'h3);
    wt(6);
    chk("external run", run_indicator, 1'b1);
    apb(1'b1, `MDS_OFF_CTRL, 32'h4);
    wt(6);
    chk("position done", {position_done_indicator, run_indicator}, 2'h2);
  endtask : t_reset_and_run
  task automatic t_encoder_timer();
    logic [31:0] t0;
    step(2'h2);
    step(2'h3);
    step(2'h1);
    step(2'h0);
    apb(1'b0, `MDS_OFF_ENC_CNT, 32'h0);
    chk("a leads count", rd, 32'hfffc);
    step(2'h1);
    step(2'h3);
    apb(1'b0, `MDS_OFF_ENC_CNT, 32'h0);
    chk("b leads count", rd, 32'hfffe);
    wt(60);
    apb(1'b0, `MDS_OFF_ENC_CAP, 32'h0);
    chk("captured count", rd, 32'hfffe);
    apb(1'b0, `MDS_OFF_FREE_TMR, 32'h0);
    t0 = rd;
    apb(1'b0, `MDS_OFF_FREE_TMR, 32'h0);
    chk("timer step", rd - t0, 32'h4);
  endtask : t_encoder_timer
  task automatic t_events();
    apb(1'b1, `MDS_OFF_IRQ_EN, 32'h1);
    wt(60);
    chk("tick irq", irq, 1'b1);
    apb(1'b1, `MDS_OFF_IRQ_EN, 32'h0);
    wt(3);
    chk("masked irq", irq, 1'b0);
    apb(1'b1, `MDS_OFF_IRQ_CLR, 32'h3f);
    hall_u_event <= 1'b1;
    wt(6);
    apb(1'b0, `MDS_OFF_IRQ_STAT, 32'h0);
    chk("hall event", rd & 32'he, 32'h2);
    hall_v_event <= 1'b1;
    hall_w_event <= 1'b1;
    wt(6);
    apb(1'b0, `MDS_OFF_IRQ_STAT, 32'h0);
    chk("hall events", rd & 32'he, 32'he);
  endtask : t_events
  task automatic t_faults();
    apb(1'b1, `MDS_OFF_CTRL, 32'h0);
    run_toggle_switch <= 1'b0;
    overcurrent_stop_n <= 1'b0;
    wt(10);
    chk("oc float", {gate_oe, fault_indicator, run_indicator}, 3'h2);
    press();
    chk("fault held", {gate_oe, fault_indicator}, 2'h1);
    overcurrent_stop_n <= 1'b1;
    press();
    chk("fault cleared", {gate_oe, fault_indicator}, 2'h2);
    short_detect <= 1'b1;
    wt(10);
    chk("short float", gate_oe, 1'b0);
    short_detect <= 1'b0;
    press();
    chk("short cleared", gate_oe, 1'b1);
  endtask : t_faults
  task automatic t_scan();
    int n, sh, shoot, lon;
    n = 0; sh = 0; shoot = 0; lon = 0;
    apb(1'b1, `MDS_OFF_DUTY_U, 32'h20);
    apb(1'b1, `MDS_OFF_IRQ_CLR, 32'h3f);
    apb(1'b1, `MDS_OFF_IRQ_EN, 32'h20);
    // The short period puts the carrier at its top at once, so the scan starts here.
    apb(1'b1, `MDS_OFF_PERIOD, 32'h40);
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      if (sample_hold === 1'b1) sh++;
      if (gate_u_low === 1'b1) lon++;
      if (gate_u_high === 1'b0 && gate_u_low === 1'b1) shoot++;
    end
    chk("scan done irq", irq, 1'b1);
    chk("held once", sh, 1);
    chk("no overlap", shoot, 0);
    chk("low side used", lon != 0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, `MDS_OFF_ADC_IU + 8'(4 * c), 32'h0);
      chk("sample", rd, 32'h5a0 | c);
    end
  endtask : t_scan
  initial begin
    wt(2);
    rst <= 1'b0;
    t_reset_and_run();
    t_encoder_timer();
    t_events();
    t_faults();
    t_scan();
    summarize();
  end
endmodule : tb
